// ==== hdl/pmbp_burst_policy.sv ====
module pmbp_burst_policy #(
  parameter int DW_W = 12                       // width of doubleword counts
) (
  input  wire logic            clk,             // bus clock, 100 MHz
  input  wire logic            sys_rst,         // synchronous reset, active high
  // wishbone slave
  input  wire logic [7:0]      wb_adr_i,        // byte address
  input  wire logic [31:0]     wb_dat_i,        // write data
  input  wire logic [3:0]      wb_sel_i,        // byte lanes
  input  wire logic            wb_we_i,         // write
  input  wire logic            wb_cyc_i,        // cycle
  input  wire logic            wb_stb_i,        // strobe
  output logic      [31:0]     wb_dat_o,        // read data
  output logic                 wb_ack_o,        // acknowledge
  // receive write dma
  input  wire logic            rxStart,         // new write burst request pulse
  input  wire logic            rxIsData,        // burst carries receive data
  input  wire logic            rxBeat,          // one data phase done
  input  wire logic [31:0]     rxAddr,          // address of start or beat
  input  wire logic [DW_W-1:0] rxFifoDw,        // doublewords in receive FIFO
  input  wire logic [DW_W-1:0] rxRoomDw,        // room in host buffer
  output logic                 rxGo,            // burst accepted pulse
  output logic                 rxCmdMwi,        // use invalidate command
  output logic                 rxBeAllN,        // force all byte enables
  output logic                 rxStop,          // end burst pulse
  // transmit read dma
  input  wire logic            txStart,         // read burst request pulse
  input  wire logic            txBeat,          // one data phase done
  input  wire logic [31:0]     txAddr,          // address of beat
  input  wire logic            txAlmostFull,    // transmit FIFO nearly full
  input  wire logic            txMaxReached,    // max transfer count reached
  input  wire logic            otherPending,    // other channels waiting
  output logic                 txGo,            // read burst accepted pulse
  output logic                 txStop,          // end read burst pulse
  // control structure fetch
  input  wire logic            ctlReq,          // fetch request pulse
  input  wire logic [31:0]     ctlBase,         // structure base address
  output logic                 ctlGo,           // fetch accepted pulse
  output logic      [31:0]     ctlAddr,         // fetch start address
  // parity and pins
  input  wire logic            parErr,          // data parity error as initiator
  input  wire logic            parErrRead,      // error was during a read
  output logic                 perrOe,          // drive perr low
  input  wire logic            strapPin,        // host_bus_type_strap pin
  input  wire logic            clkRunPin,       // clkrun wire level
  output logic                 clkRunOe,        // pull clkrun low
  input  wire logic            dmaBusy,         // dma activity needs clock
  input  wire logic            pmeEvent,        // power management event pulse
  output logic                 pmeOe,           // pull pme low (pci mode)
  output logic                 cardStsChg,      // card status change (cardbus)
  output logic                 cardbusMode      // strap result
);

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic clsValid(input logic [7:0] cache_line_size);
    return (cache_line_size == pmbp_pkg::CLS_8) || (cache_line_size == pmbp_pkg::CLS_16);
  endfunction

  // doubleword index within the line; line size taken as a power of two
  function automatic logic [7:0] lineIdx(input logic [31:0] a, input logic [7:0] cache_line_size);
    return a[9:2] & (cache_line_size - 8'h01);
  endfunction

  function automatic logic lineEnd(input logic [31:0] a, input logic [7:0] cache_line_size);
    return (cache_line_size != 8'h00) && (lineIdx(a, cache_line_size) == (cache_line_size - 8'h01));
  endfunction

  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------------------
  // pin handler
  // ---------------------------------------------------------------------------
  pmbp_pin_if pinBus ();

  pmbp_pin_ctl uPins (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .strapPin  (strapPin),
    .clkRunPin (clkRunPin),
    .clkRunOe  (clkRunOe),
    .pin       (pinBus.pins)
  );

  // ---------------------------------------------------------------------------
  // register file and wishbone slave
  // ---------------------------------------------------------------------------
  logic [pmbp_pkg::CFG_W-1:0] cfg_ff, nxt_cfg;
  logic        mdpe_ff, nxt_mdpe, dpe_ff, nxt_dpe;
  logic        evt_ff, nxt_evt, mask_ff, nxt_mask;
  logic        ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic        perr_ff, nxt_perr;
  logic        cbus_ff, nxt_cbus;

  logic [7:0]  cache_line_size;
  logic        inD0, parResp, reqOk, wrHit;
  logic [31:0] cfgWord, statWord, wdat;

  assign cache_line_size     = cfg_ff[pmbp_pkg::CFG_CLS_LSB +: pmbp_pkg::CFG_CLS_W];
  assign inD0    = cfg_ff[pmbp_pkg::CFG_PSTATE_LSB +: 2] == pmbp_pkg::PSTATE_D0;
  assign parResp = cfg_ff[pmbp_pkg::CFG_PAR_RESP];
  assign reqOk   = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wrHit   = reqOk && wb_we_i;
  assign wdat    = wb_dat_i;

  always_comb begin
    cfgWord  = 32'h0000_0000;
    cfgWord[pmbp_pkg::CFG_W-1:0] = cfg_ff;
    statWord = 32'h0000_0000;
    statWord[pmbp_pkg::STAT_MDPE]   = mdpe_ff;
    statWord[pmbp_pkg::STAT_DPE]    = dpe_ff;
    statWord[pmbp_pkg::STAT_CBUS]   = cbus_ff;
    statWord[pmbp_pkg::STAT_CLKREQ] = pinBus.claiming;
  end

  // one-wait-state slave; status bits clear on write-one, hardware set wins
  always_comb begin
    logic [31:0] m;
    m         = laneMerge(cfgWord, wdat, wb_sel_i);
    nxt_ack   = reqOk;
    nxt_rdat  = 32'h0000_0000;
    nxt_cfg   = cfg_ff;
    nxt_mdpe  = mdpe_ff;
    nxt_dpe   = dpe_ff;
    nxt_evt   = evt_ff;
    nxt_mask  = mask_ff;
    nxt_perr  = 1'b0;
    nxt_cbus  = cbus_ff;
    if (wrHit) begin
      case (wb_adr_i)
        pmbp_pkg::REG_CFG:  nxt_cfg = m[pmbp_pkg::CFG_W-1:0];
        pmbp_pkg::REG_STAT: begin
          if (wb_sel_i[0] && wdat[pmbp_pkg::STAT_MDPE]) nxt_mdpe = 1'b0;
          if (wb_sel_i[0] && wdat[pmbp_pkg::STAT_DPE])  nxt_dpe  = 1'b0;
        end
        pmbp_pkg::REG_EVT:  if (wb_sel_i[0] && wdat[pmbp_pkg::EVT_PME]) nxt_evt = 1'b0;
        pmbp_pkg::REG_MASK: if (wb_sel_i[0]) nxt_mask = wdat[pmbp_pkg::EVT_PME];
        pmbp_pkg::REG_FORC: if (wb_sel_i[0] && wdat[pmbp_pkg::EVT_PME]) nxt_evt = 1'b1;
        default: ;
      endcase
    end else if (reqOk) begin
      case (wb_adr_i)
        pmbp_pkg::REG_CFG:  nxt_rdat = cfgWord;
        pmbp_pkg::REG_STAT: nxt_rdat = statWord;
        pmbp_pkg::REG_EVT:  nxt_rdat = {31'h0000_0000, evt_ff};
        pmbp_pkg::REG_MASK: nxt_rdat = {31'h0000_0000, mask_ff};
        pmbp_pkg::REG_PRES: nxt_rdat = {31'h0000_0000, evt_ff && mask_ff};
        default:            nxt_rdat = 32'h0000_0000;
      endcase
    end
    // set after clear so a same-cycle error is never lost
    if (parErr && parResp) begin
      nxt_perr = 1'b1;
      nxt_mdpe = 1'b1;
    end
    if (parErr && parErrRead) begin
      nxt_dpe = 1'b1;
    end
    if (pmeEvent) begin
      nxt_evt = 1'b1;
    end
    // strap follows the pin while reset is held and freezes at release
    if (sys_rst) begin
      nxt_cbus = pinBus.strapLvl;
    end
  end

  always_ff @(posedge clk) begin
    cbus_ff <= nxt_cbus;
    if (sys_rst) begin
      cfg_ff  <= pmbp_pkg::CFG_RESET;
      mdpe_ff <= 1'b0;
      dpe_ff  <= 1'b0;
      evt_ff  <= 1'b0;
      mask_ff <= 1'b0;
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
      perr_ff <= 1'b0;
    end else begin
      cfg_ff  <= nxt_cfg;
      mdpe_ff <= nxt_mdpe;
      dpe_ff  <= nxt_dpe;
      evt_ff  <= nxt_evt;
      mask_ff <= nxt_mask;
      ack_ff  <= nxt_ack;
      rdat_ff <= nxt_rdat;
      perr_ff <= nxt_perr;
    end
  end

  // ---------------------------------------------------------------------------
  // receive write command policy
  // ---------------------------------------------------------------------------
  pmbp_pkg::pmbp_rx_st_t rxSt_ff, nxt_rxSt;
  logic rxGo_ff, nxt_rxGo, rxStop_ff, nxt_rxStop;
  logic mwiAllowed, mwiStartOk, mwiNextOk;

  // enables, line size, resources and data-only, evaluated every cycle
  always_comb begin
    mwiAllowed = clsValid(cache_line_size)
                 && (rxFifoDw >= DW_W'(cache_line_size)) && (rxRoomDw >= DW_W'(cache_line_size))
                 && cfg_ff[pmbp_pkg::CFG_MWI_CMD]
                 && cfg_ff[pmbp_pkg::CFG_MWI_CFG]
                 && rxIsData;
    mwiStartOk = mwiAllowed && (lineIdx(rxAddr, cache_line_size) == 8'h00);
    // FIFO and room already exclude the beat just moved
    mwiNextOk  = mwiAllowed;
  end

  always_comb begin
    nxt_rxSt   = rxSt_ff;
    nxt_rxGo   = 1'b0;
    nxt_rxStop = 1'b0;
    case (rxSt_ff)
      pmbp_pkg::RX_IDLE: begin
        if (rxStart && inD0) begin
          nxt_rxGo = 1'b1;
          nxt_rxSt = mwiStartOk ? pmbp_pkg::RX_MWI : pmbp_pkg::RX_MW;
        end
      end
      pmbp_pkg::RX_MWI: begin
        // lines complete whole; cross only when the next one can complete too
        if (rxBeat && lineEnd(rxAddr, cache_line_size) && !mwiNextOk) begin
          nxt_rxStop = 1'b1;
          nxt_rxSt   = pmbp_pkg::RX_IDLE;
        end
      end
      pmbp_pkg::RX_MW: begin
        if (rxBeat && lineEnd(rxAddr, cache_line_size) && cfg_ff[pmbp_pkg::CFG_TERM_LINE]) begin
          nxt_rxStop = 1'b1;
          nxt_rxSt   = pmbp_pkg::RX_IDLE;
        end
      end
      default: nxt_rxSt = pmbp_pkg::RX_IDLE;
    endcase
    if (rxStart && rxSt_ff != pmbp_pkg::RX_IDLE) begin
      // dma engine closed the burst itself; choose afresh
      nxt_rxGo = inD0;
      nxt_rxSt = !inD0 ? pmbp_pkg::RX_IDLE
                       : (mwiStartOk ? pmbp_pkg::RX_MWI : pmbp_pkg::RX_MW);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxSt_ff   <= pmbp_pkg::RX_IDLE;
      rxGo_ff   <= 1'b0;
      rxStop_ff <= 1'b0;
    end else begin
      rxSt_ff   <= nxt_rxSt;
      rxGo_ff   <= nxt_rxGo;
      rxStop_ff <= nxt_rxStop;
    end
  end

  // ---------------------------------------------------------------------------
  // transmit read alignment and control fetch
  // ---------------------------------------------------------------------------
  logic        txGo_ff, nxt_txGo, txStop_ff, nxt_txStop;
  logic        ctlGo_ff, nxt_ctlGo;
  logic [31:0] ctlAddr_ff, nxt_ctlAddr;
  logic        alignOn, yieldReq;

  assign alignOn  = cfg_ff[pmbp_pkg::CFG_RD_ALIGN];
  assign yieldReq = cfg_ff[pmbp_pkg::CFG_TXMAX_EN] && txMaxReached && otherPending;

  // aligned mode trades burst length for line-aligned restarts
  always_comb begin
    nxt_txGo    = txStart && inD0;
    nxt_txStop  = 1'b0;
    nxt_ctlGo   = ctlReq && inD0;
    nxt_ctlAddr = ctlAddr_ff;
    if (txBeat) begin
      if (alignOn) begin
        if ((txAlmostFull || yieldReq) && lineEnd(txAddr, cache_line_size)) begin
          nxt_txStop = 1'b1;
        end
      end else if (yieldReq) begin
        nxt_txStop = 1'b1;
      end
    end
    if (ctlReq && inD0) begin
      nxt_ctlAddr = ctlBase;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txGo_ff    <= 1'b0;
      txStop_ff  <= 1'b0;
      ctlGo_ff   <= 1'b0;
      ctlAddr_ff <= 32'h0000_0000;
    end else begin
      txGo_ff    <= nxt_txGo;
      txStop_ff  <= nxt_txStop;
      ctlGo_ff   <= nxt_ctlGo;
      ctlAddr_ff <= nxt_ctlAddr;
    end
  end

  // ---------------------------------------------------------------------------
  // clock request and power event pins
  // ---------------------------------------------------------------------------
  logic pme_ff, nxt_pme, csc_ff, nxt_csc;

  // disabled request function means the clock is claimed even when idle
  assign pinBus.needClk = dmaBusy || cfg_ff[pmbp_pkg::CFG_CLKREQ_DIS];

  always_comb begin
    nxt_pme = !cbus_ff && evt_ff && mask_ff;
    nxt_csc = cbus_ff && evt_ff && mask_ff;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pme_ff <= 1'b0;
      csc_ff <= 1'b0;
    end else begin
      pme_ff <= nxt_pme;
      csc_ff <= nxt_csc;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign wb_dat_o    = rdat_ff;
  assign wb_ack_o    = ack_ff;
  assign rxGo        = rxGo_ff;
  assign rxCmdMwi    = rxSt_ff == pmbp_pkg::RX_MWI;
  assign rxBeAllN    = rxSt_ff == pmbp_pkg::RX_MWI;      // all lanes in invalidate
  assign rxStop      = rxStop_ff;
  assign txGo        = txGo_ff;
  assign txStop      = txStop_ff;
  assign ctlGo       = ctlGo_ff;
  assign ctlAddr     = ctlAddr_ff;
  assign perrOe      = perr_ff;
  assign pmeOe       = pme_ff;
  assign cardStsChg  = csc_ff;
  assign cardbusMode = cbus_ff;

endmodule

// ==== hdl/pmbp_pin_ctl.sv ====
module pmbp_pin_ctl (
  input  wire logic clk,          // bus clock
  input  wire logic sys_rst,      // synchronous reset
  input  wire logic strapPin,     // host_bus_type_strap pin
  input  wire logic clkRunPin,    // clkrun wire level
  output logic      clkRunOe,     // pull clkrun low when high
  pmbp_pin_if.pins  pin           // to policy core
);

  // ---------------------------------------------------------------------------
  // two-stage synchronisers; first stage is read only by the second
  // ---------------------------------------------------------------------------
  logic strapS1_ff, strapS2_ff, runS1_ff, runS2_ff;
  logic nxt_strapS1, nxt_strapS2, nxt_runS1, nxt_runS2;

  always_comb begin
    nxt_strapS1 = strapPin;
    nxt_strapS2 = strapS1_ff;
    nxt_runS1   = clkRunPin;
    nxt_runS2   = runS1_ff;
  end

  always_ff @(posedge clk) begin
    strapS1_ff <= nxt_strapS1;
    strapS2_ff <= nxt_strapS2;
    runS1_ff   <= nxt_runS1;
    runS2_ff   <= nxt_runS2;
  end

  assign pin.strapLvl   = strapS2_ff;
  assign pin.clkRunHigh = runS2_ff;

  // ---------------------------------------------------------------------------
  // clock claim: when the host lets clkrun float high and the device still
  // needs the clock, pull the wire low for a short hold, then release
  // ---------------------------------------------------------------------------
  logic       oe_ff, nxt_oe;
  logic [1:0] hold_ff, nxt_hold;

  always_comb begin
    nxt_oe   = oe_ff;
    nxt_hold = hold_ff;
    if (oe_ff) begin
      if (hold_ff == 2'(pmbp_pkg::CLKRUN_HOLD - 1)) begin
        nxt_oe   = 1'b0;
        nxt_hold = 2'h0;
      end else begin
        nxt_hold = hold_ff + 2'h1;
      end
    end else if (pin.needClk && runS2_ff) begin
      nxt_oe = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      oe_ff   <= 1'b0;
      hold_ff <= 2'h0;
    end else begin
      oe_ff   <= nxt_oe;
      hold_ff <= nxt_hold;
    end
  end

  assign clkRunOe     = oe_ff;
  assign pin.claiming = oe_ff;

endmodule

// ==== hdl/pmbp_pin_if.sv ====
// pin-side signals shared between the policy core and the pin handler
interface pmbp_pin_if;
  logic strapLvl;    // synchronised host bus type strap
  logic clkRunHigh;  // synchronised clkrun pin is high (host deasserted)
  logic needClk;     // core wants the bus clock
  logic claiming;    // pin handler is pulling clkrun low

  modport core (input strapLvl, input clkRunHigh, input claiming, output needClk);
  modport pins (output strapLvl, output clkRunHigh, output claiming, input needClk);
endinterface

// ==== hdl/pmbp_pkg.sv ====
package pmbp_pkg;

  // ---------------------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] REG_CFG  = 8'h00;  // policy configuration
  localparam logic [7:0] REG_STAT = 8'h04;  // error and mode status
  localparam logic [7:0] REG_EVT  = 8'h08;  // card status change event
  localparam logic [7:0] REG_MASK = 8'h0C;  // card status change mask
  localparam logic [7:0] REG_PRES = 8'h10;  // present state
  localparam logic [7:0] REG_FORC = 8'h14;  // force event

  // ---------------------------------------------------------------------------
  // configuration fields
  // ---------------------------------------------------------------------------
  localparam int CFG_CLS_LSB   = 0;   // cache line size, doublewords, 8 bits
  localparam int CFG_CLS_W     = 8;
  localparam int CFG_MWI_CMD   = 8;   // invalidate enable, command register copy
  localparam int CFG_PAR_RESP  = 9;   // parity error response
  localparam int CFG_MWI_CFG   = 10;  // invalidate enable, device option
  localparam int CFG_TERM_LINE = 11;  // terminate write on cache line
  localparam int CFG_RD_ALIGN  = 12;  // read align enable
  localparam int CFG_CLKREQ_DIS = 13; // clock request function disabled
  localparam int CFG_PSTATE_LSB = 14; // power state, 2 bits
  localparam int CFG_TXMAX_EN  = 16;  // transmit max transfer count in use
  localparam int CFG_W         = 17;
  localparam logic [CFG_W-1:0] CFG_RESET = 17'h0_0000;

  // ---------------------------------------------------------------------------
  // status fields
  // ---------------------------------------------------------------------------
  localparam int STAT_MDPE   = 0;  // master data parity error (w1c)
  localparam int STAT_DPE    = 1;  // detected parity error (w1c)
  localparam int STAT_CBUS   = 2;  // cardbus mode from strap
  localparam int STAT_CLKREQ = 3;  // device is claiming the clock
  localparam int EVT_PME     = 0;  // power management event bit

  // ---------------------------------------------------------------------------
  // encodings and constants
  // ---------------------------------------------------------------------------
  localparam logic [1:0] PSTATE_D0 = 2'h0;
  localparam logic [7:0] CLS_8     = 8'h08;
  localparam logic [7:0] CLS_16    = 8'h10;
  localparam logic [3:0] BE_ALL_N  = 4'h0;   // all byte enables active (low)
  localparam int         CLKRUN_HOLD = 2;    // cycles the device pulls clkrun low

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_MWI,
    RX_MW
  } pmbp_rx_st_t;

endpackage

// ==== verification/pmbp_burst_policy_tb.sv ====
module pmbp_burst_policy_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, sys_rst = 1, cyc = 0, we = 0, ack, rxStart = 0, rxIsData = 1, rxBeat = 0;
  logic        rxGo, rxCmdMwi, rxStop, txStop, perrOe, parErr = 0, strapPin = 1, clkRun, clkRunOe;
  logic        dmaBusy = 0, stopReq = 0, txAlmostFull = 1, ctlGo, cardStsChg, pmeOe;
  logic        txYield = 0, txGo;
  logic [7:0]  adr = 0;
  logic [31:0] wdat = 0, rdat, rd, rxAddr = 0, ctlAddr;
  logic [11:0] rxFifoDw = 12'h010, rxRoomDw = 12'h010;
  int          fails = 0, checksDone = 0;
  always #5 clk = ~clk;
  // transmit and fetch requests ride on the receive stimulus
  pmbp_burst_policy u_dut (.clk, .sys_rst, .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i({4{cyc}}),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rdat), .wb_ack_o(ack), .rxStart,
    .rxIsData, .rxBeat, .rxAddr, .rxFifoDw, .rxRoomDw, .rxGo, .rxCmdMwi, .rxBeAllN(), .rxStop,
    .txStart(rxStart), .txBeat(rxBeat), .txAddr(rxAddr), .txAlmostFull, .txMaxReached(txYield),
    .otherPending(txYield), .txGo, .txStop, .ctlReq(rxStart), .ctlBase(rxAddr), .ctlGo, .ctlAddr,
    .parErr, .parErrRead(rxIsData), .perrOe, .strapPin, .clkRunPin(clkRun), .clkRunOe, .dmaBusy,
    .pmeEvent(1'h0), .pmeOe, .cardStsChg, .cardbusMode());
  pmbp_host_model u_host (.clk, .stopReq, .devOe(clkRunOe), .clkRun);
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      $display("BAD %s exp %h got %h", nm, exp, got);
      fails++;
    end
  endtask
  task automatic results();
    $display("checks %0d fails %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one classic cycle; a slave that never answers ends the run
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, we, adr, wdat} <= {1'h1, w, a, d};
    do @(posedge clk); while (ack !== 1'h1 && ++n < 20);
    q = rdat;
    cyc <= 1'h0;
    if (n >= 20) begin
      fails++;
      results();
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    bus(1'h1, a, d, rd);
  endtask
  task automatic rxTry(logic [31:0] cfg, logic [31:0] a, logic dat, logic [11:0] fifo,
                       logic go, logic mwi);
    wr(pmbp_pkg::REG_CFG, cfg);
    @(posedge clk);
    {rxAddr, rxIsData, rxFifoDw, rxRoomDw, rxStart} <= {a, dat, fifo, 12'h010, 1'h1};
    @(posedge clk);
    rxStart <= 1'h0;
    #1;
    chk("rxGo", go, rxGo);
    chk("txGo", go, txGo);
    chk("ctlGo", go, ctlGo);
    if (go) chk("ctlAddr", a, ctlAddr);
    if (go) chk("rxCmdMwi", mwi, rxCmdMwi);
  endtask
  // eight beats of one line, the buffer running short after the start
  task automatic burst(logic [31:0] cfg, logic rxEnd, logic txEnd);
    rxTry(cfg, 32'h0000_0100, 1'h1, 12'h010, 1'h1, cfg[8] && cfg[10]);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {rxBeat, rxRoomDw, rxAddr} <= {1'h1, 12'h004, 32'h0000_0100 + 32'(4 * i)};
      @(posedge clk);
      rxBeat <= 1'h0;
      #1;
      chk("rxStop", rxEnd && i == 7, rxStop);
      chk("txStop", txEnd && i == 7, txStop);
    end
  endtask
  task automatic parity(logic [31:0] cfg, logic perr, logic [31:0] stat);
    wr(pmbp_pkg::REG_CFG, cfg);
    @(posedge clk);
    parErr <= 1'h1;
    @(posedge clk);
    parErr <= 1'h0;
    #1;
    chk("perrOe", perr, perrOe);
    bus(1'h0, pmbp_pkg::REG_STAT, 0, rd);
    chk("stat", stat, rd & 32'h0000_0007);
  endtask
  // host releases clkrun; watch whether the device claims it
  task automatic claim(logic [31:0] cfg, logic busy, logic exp);
    logic seen;
    seen = 0;
    wr(pmbp_pkg::REG_CFG, cfg);
    {dmaBusy, stopReq} <= {busy, 1'h1};
    repeat (12) @(posedge clk) seen = seen | clkRunOe;
    chk("clkRunOe", exp, seen);
    {dmaBusy, stopReq} <= 2'h0;
    // let a claim still in flight settle before the next window opens
    repeat (8) @(posedge clk);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    {sys_rst, strapPin} <= 2'h0;
    rxTry(32'h0000_0508, 32'h0000_0100, 1'h1, 12'h010, 1'h1, 1'h1);
    rxTry(32'h0000_0510, 32'h0000_0140, 1'h1, 12'h010, 1'h1, 1'h1);
    rxTry(32'h0000_0504, 32'h0000_0100, 1'h1, 12'h010, 1'h1, 1'h0);
    rxTry(32'h0000_0508, 32'h0000_0104, 1'h1, 12'h010, 1'h1, 1'h0);
    rxTry(32'h0000_0508, 32'h0000_0100, 1'h1, 12'h007, 1'h1, 1'h0);
    rxTry(32'h0000_0408, 32'h0000_0100, 1'h1, 12'h010, 1'h1, 1'h0);
    rxTry(32'h0000_0108, 32'h0000_0100, 1'h1, 12'h010, 1'h1, 1'h0);
    rxTry(32'h0000_0508, 32'h0000_0100, 1'h0, 12'h010, 1'h1, 1'h0);
    rxTry(32'h0000_C508, 32'h0000_0100, 1'h1, 12'h010, 1'h0, 1'h0);
    burst(32'h0000_0808, 1'h1, 1'h0);
    burst(32'h0000_0008, 1'h0, 1'h0);
    burst(32'h0000_0508, 1'h1, 1'h0);
    burst(32'h0000_1008, 1'h0, 1'h1);
    {txAlmostFull, txYield} <= 2'h1;
    burst(32'h0001_1008, 1'h0, 1'h1);
    {txAlmostFull, txYield} <= 2'h2;
    parity(32'h0000_0000, 1'h0, 32'h0000_0006);
    parity(32'h0000_0200, 1'h1, 32'h0000_0007);
    wr(pmbp_pkg::REG_STAT, 32'h0000_0003);
    parity(32'h0000_0000, 1'h0, 32'h0000_0006);
    claim(32'h0000_0000, 1'h1, 1'h1);
    claim(32'h0000_2000, 1'h0, 1'h1);
    claim(32'h0000_0000, 1'h0, 1'h0);
    wr(pmbp_pkg::REG_MASK, 32'h0000_0001);
    wr(pmbp_pkg::REG_FORC, 32'h0000_0001);
    @(posedge clk);
    #1;
    chk("cardStsChg", 1, cardStsChg);
    chk("pmeOe", 0, pmeOe);
    bus(1'h0, 8'h40, 0, rd);
    chk("unmapped", 0, rd);
    results();
  end
endmodule
bind pmbp_burst_policy pmbp_checker #(.DW_W(DW_W)) u_chk (.*);

// ==== verification/pmbp_checker.sv ====
// watches the policy outputs against their causes at the ports
module pmbp_checker #(
  parameter int DW_W = 12                  // count width
) (
  input wire logic            clk,         // bus clock
  input wire logic            sys_rst,     // sync reset
  input wire logic            wb_cyc_i,    // cycle
  input wire logic            wb_stb_i,    // strobe
  input wire logic            wb_ack_o,    // ack
  input wire logic            rxBeat,      // beat done
  input wire logic [31:0]     rxAddr,      // address
  input wire logic [DW_W-1:0] rxFifoDw,    // fifo fill
  input wire logic [DW_W-1:0] rxRoomDw,    // buffer room
  input wire logic            rxGo,        // accepted
  input wire logic            rxCmdMwi,    // invalidate
  input wire logic            rxBeAllN,    // all lanes
  input wire logic            rxStop,      // end burst
  input wire logic            parErr,      // parity error
  input wire logic            perrOe,      // perr drive
  input wire logic            dmaBusy,     // needs clock
  input wire logic            clkRunPin,   // clkrun wire
  input wire logic            clkRunOe,    // clkrun pull
  input wire logic            cardbusMode  // strap result
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // dword within an 8 dword line; 16 dword lines end on the same value
  logic [2:0] lineOff;
  assign lineOff = rxAddr[4:2];
  // steps used by the checks; mwiGo is shared by two, wantClk serves one
  sequence mwiGo;
    rxGo && rxCmdMwi;
  endsequence
  sequence wantClk;
    (dmaBusy && clkRunPin) [*3];
  endsequence
  ack_one_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  mwi_align_a: assert property (mwiGo |-> $past(lineOff) == 3'h0)
    else $error("invalidate burst off line start");
  mwi_room_a: assert property (mwiGo |-> $past(rxFifoDw) >= 8 && $past(rxRoomDw) >= 8)
    else $error("invalidate burst without a full line");
  be_all_a: assert property (rxBeAllN == rxCmdMwi)
    else $error("lanes not forced for invalidate");
  stop_line_a: assert property (rxStop |-> $past(rxBeat) && $past(lineOff) == 3'h7)
    else $error("burst ended off a line end");
  perr_cause_a: assert property (perrOe |-> $past(parErr))
    else $error("perr without parity error");
  clk_claim_a: assert property (wantClk |-> ##[0:4] clkRunOe)
    else $error("clock need not signalled");
  strap_hold_a: assert property (!$past(sys_rst) |-> $stable(cardbusMode))
    else $error("bus type changed outside reset");
endmodule

// ==== verification/pmbp_host_model.sv ====
// host side of the clkrun wire
module pmbp_host_model (
  input  wire logic clk,      // bus clock
  input  wire logic stopReq,  // host wants the clock stopped
  input  wire logic devOe,    // device pulls clkrun low
  output logic      clkRun    // resolved wire level
);
  logic hostOe_ff = 1'h1;     // host pulls clkrun low
  // asserted while running, released before a stop, restored one cycle after
  // a device claim, well inside the allowed latency
  always_ff @(posedge clk) begin
    hostOe_ff <= !stopReq || devOe;
  end
  // open drain with pull-up: low while any party pulls
  assign clkRun = !(hostOe_ff || devOe);
endmodule
